// ==== include/rfc_pkg.sv ====
/*
  Package for the RFID front end control block: timing figures, derived
  cycle counts, mode states and packed carriers.
  Assumes a 40 MHz core clock and an RF carrier near 125 kHz.
*/
package rfc_pkg;

  // ------------------------------------------------------------
  // Clock and timing figures
  // ------------------------------------------------------------
  localparam int CORE_CLK_KHZ          = 40000;  // Core clock rate
  localparam int WAKE_SETTLE_TIME_MS   = 35;     // Settling, longest
  localparam int WAKE_SETTLE_TYP_MS    = 25;     // Settling, typical
  localparam int MODULATION_ENTRY_US   = 50;     // Entry budget
  localparam int DEMOD_DELAY_TYP_US    = 40;     // Demod delay typical
  localparam int DEMOD_DELAY_MAX_US    = 100;    // Demod delay longest
  localparam int RECEIVE_RECOVERY_US   = 500;    // Recovery budget
  localparam int RF_PERIOD_US          = 8;      // One carrier period
  // RF clocks per settling interval (longest, rounded down)
  localparam int SETTLE_RF_CLOCKS      =
    (WAKE_SETTLE_TIME_MS * 1000) / RF_PERIOD_US;
  // Entry budget in core cycles (rounded down)
  localparam int ENTRY_CYCLES          =
    (MODULATION_ENTRY_US * CORE_CLK_KHZ) / 1000;
  // Input synchroniser depth, two flops per pin; not read by the block
  localparam int DEMOD_SYNC_STAGES     = 2;
  localparam int RESUME_RF_CLOCKS      = 41;     // Hold after release
  localparam int CNT_W                 = 16;     // Counter width

  // ------------------------------------------------------------
  // Control states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RFC_SLEEP,
    RFC_SETTLE,
    RFC_RUN,
    RFC_MODULATE,
    RFC_RESUME,
    RFC_FAULT
  } rfc_state_t;

  // ------------------------------------------------------------
  // Pin carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic sleep_request;
    logic modulate_request;
    logic rf_clock;
    logic antenna_sense_input;
    logic short_detect;
  } rfc_in_t;

  typedef struct packed {
    logic antenna_drive_a;
    logic antenna_drive_a_oe_n;
    logic antenna_drive_b;
    logic antenna_drive_b_oe_n;
    logic ready_clock;
    logic ready_clock_oe_n;
    logic demodulated_output;
    logic chain_hold;
  } rfc_out_t;

endpackage

// ==== hw/rfc_frontend_ctrl.sv ====
/*
  Control and sequencing of the RFID reader front end: sleep, wake
  settling, carrier gating, modulation hold and resume, short shutdown.
  Assumes the locked carrier arrives as RF_CLK from the analog loop and
  the comparator result arrives on ANT_SENSE; both are sampled here.
*/
// Notes on behaviour
// - Settle within 35 ms after sleep release
// - Enter modulation within 50 us of request
// - Demod output follows sense within 100 us
// - Receive chain ready within 500 us after
// - RF counts measured in carrier periods
// - Sleep request high keeps field off
// - Awake: drive field, demodulate, present output
// - Modulate request tri-states drivers, carrier synchronous
// - Oscillator and demod hold during modulation
// - Wait 41 RF clocks before resuming chain
// - Short detected: tri-state driver, ready low
// - Resume after short only via sleep
// - Sleep forces ready/clock output low
// - After settling, ready/clock mirrors drive A
// - Ready/clock keeps toggling during modulation
// - During settling ready/clock undriven, pulled low
// - Ready/clock drives during partial-depth modulation
// - Sample synchronously, comparator passes asynchronously; here the comparator also goes through the two sync flops
// - Carrier locked 100-150 kHz, then held
// - Single-ended modulation: only drive A released
`timescale 1ns/100ps

module rfc_frontend_ctrl
  import rfc_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_RF_CLOCKS  // Settling RF clocks
) (
  // Clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RST_N,
  // Host pins
  input  wire logic SLEEP_REQUEST,
  input  wire logic MODULATE_REQUEST,
  output logic      DEMODULATED_OUTPUT,
  output logic      READY_CLOCK,
  output logic      READY_CLOCK_OE_N,
  // Analog side
  input  wire logic RF_CLK,
  input  wire logic ANT_SENSE,
  input  wire logic SHORT_DETECT,
  input  wire logic SINGLE_ENDED,
  output logic      ANTENNA_DRIVE_A,
  output logic      ANTENNA_DRIVE_A_OE_N,
  output logic      ANTENNA_DRIVE_B,
  output logic      ANTENNA_DRIVE_B_OE_N,
  output logic      CHAIN_HOLD
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  rfc_in_t sync1;   // First stage, read by second only
  rfc_in_t sync2;   // Second stage, safe to use
  rfc_in_t raw_in;  // Packed raw pins

  always_comb begin
    raw_in.sleep_request       = SLEEP_REQUEST;
    raw_in.modulate_request    = MODULATE_REQUEST;
    raw_in.rf_clock            = RF_CLK;
    raw_in.antenna_sense_input = ANT_SENSE;
    raw_in.short_detect        = SHORT_DETECT;
  end

  // Two flops per pin; sleep resets high so the field starts off
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= '{sleep_request: 1'b1, default: 1'b0};
      sync2 <= '{sleep_request: 1'b1, default: 1'b0};
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  // ------------------------------------------------------------
  // RF clock edge finder and single-ended strap
  // ------------------------------------------------------------
  // Mode register, declared early: the strap capture reads it
  rfc_state_t state;       // Current mode
  rfc_state_t next_state;
  logic rf_prev;       // Previous synced RF level
  logic next_rf_prev;
  logic rf_rise;       // One carrier period boundary
  logic se_mode;       // Wiring option, caught while in sleep
  logic next_se_mode;
  logic se_sync1;      // Strap synchroniser
  logic se_sync2;

  always_comb begin
    next_rf_prev = sync2.rf_clock;
    rf_rise      = sync2.rf_clock & ~rf_prev;
    next_se_mode = (state == RFC_SLEEP) ? se_sync2 : se_mode;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rf_prev  <= 1'b0;
      se_sync1 <= 1'b0;
      se_sync2 <= 1'b0;
      se_mode  <= 1'b0;
    end else begin
      rf_prev  <= next_rf_prev;
      se_sync1 <= SINGLE_ENDED;
      se_sync2 <= se_sync1;
      se_mode  <= next_se_mode;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [CNT_W-1:0] count;       // RF clock counter
  logic [CNT_W-1:0] next_count;
  logic             mod_rf;      // Request aligned to carrier
  logic             next_mod_rf;

  always_comb begin
    next_state  = state;
    next_count  = count;
    next_mod_rf = mod_rf;
    // Request only changes on a carrier boundary, no partial period
    if (rf_rise) begin
      next_mod_rf = sync2.modulate_request;
    end
    if (sync2.sleep_request) begin
      // Sleep wins over everything, also the only exit from fault
      next_state = RFC_SLEEP;
      next_count = '0;
    end else begin
      case (state)
        RFC_SLEEP: begin
          next_state = RFC_SETTLE;
          next_count = '0;
        end
        RFC_SETTLE: begin
          // Lock and operating point settle, counted in RF clocks
          if (rf_rise) begin
            next_count = count + 1'b1;
          end
          if (count >= CNT_W'(SETTLE_COUNT)) begin
            next_state = RFC_RUN;
            next_count = '0;
          end
        end
        RFC_RUN: begin
          if (mod_rf) begin
            next_state = RFC_MODULATE;
          end
        end
        RFC_MODULATE: begin
          if (!mod_rf) begin
            next_state = RFC_RESUME;
            next_count = '0;
          end
        end
        RFC_RESUME: begin
          if (mod_rf) begin
            next_state = RFC_MODULATE;
          end else begin
            if (rf_rise) begin
              next_count = count + 1'b1;
            end
            if (count >= CNT_W'(RESUME_RF_CLOCKS)) begin
              next_state = RFC_RUN;
              next_count = '0;
            end
          end
        end
        RFC_FAULT: begin
          next_state = RFC_FAULT;
        end
        default: begin
          next_state = RFC_SLEEP;
        end
      endcase
      // Short outranks normal operation once awake
      if (sync2.short_detect && state != RFC_SLEEP) begin
        next_state = RFC_FAULT;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state  <= RFC_SLEEP;
      count  <= '0;
      mod_rf <= 1'b0;
    end else begin
      state  <= next_state;
      count  <= next_count;
      mod_rf <= next_mod_rf;
    end
  end

  // ------------------------------------------------------------
  // Output stage
  // ------------------------------------------------------------
  rfc_out_t outs;       // Registered pins
  rfc_out_t next_outs;
  logic     field_on;   // Drivers may toggle
  logic     clk_out_on; // Ready/clock active

  always_comb begin
    field_on   = (state == RFC_SETTLE) || (state == RFC_RUN) ||
                 (state == RFC_RESUME);
    clk_out_on = (state == RFC_RUN) || (state == RFC_MODULATE) ||
                 (state == RFC_RESUME);
    next_outs = '0;
    // Drivers tri-stated unless field is on
    next_outs.antenna_drive_a      = field_on & sync2.rf_clock;
    next_outs.antenna_drive_a_oe_n = ~field_on;
    next_outs.antenna_drive_b      = field_on & ~sync2.rf_clock;
    // Single-ended wiring only releases drive A on modulation
    next_outs.antenna_drive_b_oe_n =
      ~(field_on || (se_mode && state == RFC_MODULATE));
    if (se_mode && state == RFC_MODULATE) begin
      next_outs.antenna_drive_b = ~sync2.rf_clock;
    end
    // Settle leaves the pin to the weak pull-down; sleep forces low
    next_outs.ready_clock      = clk_out_on & sync2.rf_clock;
    next_outs.ready_clock_oe_n = (state == RFC_SETTLE);
    // Hold chain while modulating and through the resume wait
    next_outs.chain_hold =
      (state == RFC_MODULATE) || (state == RFC_RESUME);
    // Comparator result passes; held level kept while chain frozen
    if (next_outs.chain_hold) begin
      next_outs.demodulated_output = outs.demodulated_output;
    end else begin
      next_outs.demodulated_output =
        clk_out_on & sync2.antenna_sense_input;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      outs <= '{antenna_drive_a_oe_n: 1'b1, antenna_drive_b_oe_n: 1'b1,
                default: 1'b0};
    end else begin
      outs <= next_outs;
    end
  end

  assign ANTENNA_DRIVE_A      = outs.antenna_drive_a;
  assign ANTENNA_DRIVE_A_OE_N = outs.antenna_drive_a_oe_n;
  assign ANTENNA_DRIVE_B      = outs.antenna_drive_b;
  assign ANTENNA_DRIVE_B_OE_N = outs.antenna_drive_b_oe_n;
  assign READY_CLOCK          = outs.ready_clock;
  assign READY_CLOCK_OE_N     = outs.ready_clock_oe_n;
  assign DEMODULATED_OUTPUT   = outs.demodulated_output;
  assign CHAIN_HOLD           = outs.chain_hold;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_mod_seen;
    mod_rf && state == RFC_RUN;
  endsequence
  sequence s_drivers_off;
    outs.antenna_drive_a_oe_n;
  endsequence

  property p_sleep_ready_low;
    @(posedge CORE_CLK) disable iff (!RST_N)
      sync2.sleep_request |=> ##1 (!READY_CLOCK && !READY_CLOCK_OE_N);
  endproperty
  a_sleep_ready_low: assert property (p_sleep_ready_low)
    else $error("ready clock not low in sleep");

  property p_sleep_field_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
      sync2.sleep_request |=> ##1 ANTENNA_DRIVE_A_OE_N;
  endproperty
  a_sleep_field_off: assert property (p_sleep_field_off)
    else $error("field on during sleep");

  property p_mod_entry;
    @(posedge CORE_CLK) disable iff (!RST_N)
      s_mod_seen |-> ##[1:2] s_drivers_off;
  endproperty
  a_mod_entry: assert property (p_mod_entry)
    else $error("drivers not off after modulate");

  property p_short_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == RFC_FAULT) |=> (ANTENNA_DRIVE_A_OE_N && !READY_CLOCK);
  endproperty
  a_short_off: assert property (p_short_off)
    else $error("short not shut down");

  property p_fault_sticky;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == RFC_FAULT && !sync2.sleep_request) |=>
        (state == RFC_FAULT);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault left without sleep");

  property p_settle_undriven;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == RFC_SETTLE) |=> READY_CLOCK_OE_N;
  endproperty
  a_settle_undriven: assert property (p_settle_undriven)
    else $error("ready clock driven in settling");

  property p_resume_wait;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == RFC_RUN && $past(state) == RFC_RESUME) |->
        $past(count) >= CNT_W'(RESUME_RF_CLOCKS);
  endproperty
  a_resume_wait: assert property (p_resume_wait)
    else $error("resumed before 41 RF clocks");

  property p_hold_modulate;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == RFC_MODULATE) |=> CHAIN_HOLD;
  endproperty
  a_hold_modulate: assert property (p_hold_modulate)
    else $error("chain not held in modulation");

  property p_ready_mirrors;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == RFC_RUN && $past(state) == RFC_RUN) |=>
        (READY_CLOCK == ANTENNA_DRIVE_A);
  endproperty
  a_ready_mirrors: assert property (p_ready_mirrors)
    else $error("ready clock differs from drive A");

endmodule

// ==== test/rfc_host_model.sv ====
/*
  Host side model: turns bench commands into the sleep and modulate
  pins and samples the demodulated data once the ready clock shows.
  Assumes it shares the core clock and reset with the device.
*/
`timescale 1ns/100ps
module rfc_host_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench commands
  input  wire logic want_sleep,
  input  wire logic want_mod,
  // Device pins
  input  wire logic ready_clock,
  input  wire logic demod,
  output logic      sleep_request,
  output logic      modulate_request,
  // Host view
  output logic      clock_seen,
  output logic      data
);
  // ----------------------------------------------------------
  // Pin drive and sampling
  // ----------------------------------------------------------
  // Sleep stays high through reset so the device starts clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_request    <= 1'b1;
      modulate_request <= 1'b0;
      clock_seen       <= 1'b0;
      data             <= 1'b0;
    end else begin
      sleep_request    <= want_sleep;
      modulate_request <= want_mod;
      // Cleared in sleep: a restart must show the clock again
      if (sleep_request) begin
        clock_seen <= 1'b0;
      end else if (ready_clock) begin
        clock_seen <= 1'b1;
      end
      // Data is only trusted after the clock appeared
      if (clock_seen) begin
        data <= demod;
      end
    end
  end
endmodule

// ==== test/rfc_frontend_ctrl_tb.sv ====
/*
  Self-checking bench for the front end control block.
  Assumes the design package, a 40 MHz core clock and a 200 ns carrier.
*/
`timescale 1ns/100ps
module rfc_frontend_ctrl_tb;
  import rfc_pkg::*;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  localparam int SC  = 4;   // Short settle keeps the run brief
  localparam int RFP = 8;   // Core cycles per carrier period
  logic        core_clk   = 1'b0;  // Core clock
  logic        rst_n      = 1'b0;  // Reset, active low
  logic        rf_clk     = 1'b0;  // Carrier from the loop
  logic        sense      = 1'b0;  // Comparator result
  logic        short_det  = 1'b0;  // Antenna short flag
  logic        single     = 1'b0;  // Wiring option
  logic        want_sleep = 1'b1;  // Host command
  logic        want_mod   = 1'b0;  // Host command
  logic        sleep_req, mod_req, seen, data;
  logic        dmo, rdy, rdy_oe_n, ant_a, a_oe_n, ant_b, b_oe_n, hold;
  int          error_cnt  = 0;     // Mismatches
  int          cmp_count  = 0;     // Comparisons
  int unsigned seed       = 15;    // Xorshift state

  always #12.5 core_clk = ~core_clk;
  // Carrier phase is offset so its edges never meet the core clock
  initial begin
    #7;
    forever #100 rf_clk = ~rf_clk;
  end

  rfc_host_model host (.clk(core_clk), .rst_n(rst_n),
    .want_sleep(want_sleep), .want_mod(want_mod), .ready_clock(rdy),
    .demod(dmo), .sleep_request(sleep_req), .modulate_request(mod_req),
    .clock_seen(seen), .data(data));

  rfc_frontend_ctrl #(.SETTLE_COUNT(SC)) dut (.CORE_CLK(core_clk),
    .RST_N(rst_n), .SLEEP_REQUEST(sleep_req), .MODULATE_REQUEST(mod_req),
    .DEMODULATED_OUTPUT(dmo), .READY_CLOCK(rdy),
    .READY_CLOCK_OE_N(rdy_oe_n), .RF_CLK(rf_clk), .ANT_SENSE(sense),
    .SHORT_DETECT(short_det), .SINGLE_ENDED(single),
    .ANTENNA_DRIVE_A(ant_a), .ANTENNA_DRIVE_A_OE_N(a_oe_n),
    .ANTENNA_DRIVE_B(ant_b), .ANTENNA_DRIVE_B_OE_N(b_oe_n),
    .CHAIN_HOLD(hold));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[0];
  endfunction

  // Sample 1 ns after the edge so the edge's updates have landed
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return rdy_oe_n;
      1: return a_oe_n;
      default: return hold;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a mismatch
  task automatic wait_for(input int s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      chk_n(n, 0, lim - 1);
      results();
    end
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Sleep, pick the wiring, wake and follow the settle sequence
  task automatic wake(input logic se);
    int n;
    @(posedge core_clk) begin
      want_sleep <= 1'b1;
      single     <= se;
    end
    tick(12);
    chk(rdy, 1'b0);
    chk(a_oe_n, 1'b1);
    chk(b_oe_n, 1'b1);
    @(posedge core_clk) want_sleep <= 1'b0;
    wait_for(0, 1'b1, 16, n);
    tick(1);
    chk(rdy, 1'b0);
    chk(a_oe_n, 1'b0);
    chk(b_oe_n, 1'b0);
    wait_for(0, 1'b0, SC * RFP + 40, n);
    n = 0;
    // Ready clock must track drive A edge for edge
    for (int i = 0; i < 40; i++) begin
      tick(1);
      chk(rdy, ant_a);
      chk(ant_b, ~ant_a);
      n += rdy;
    end
    chk_n(n, 10, 30);
    chk(seen, 1'b1);
    // Partial-depth wiring: host waits one more settle before reading
    if (se) tick(SC * RFP);
  endtask

  // Random sense levels must come through within the budget
  task automatic demod_run();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk) sense <= rnd();
      tick(8);
      chk(dmo, sense);
      chk(data, sense);
    end
  endtask

  task automatic modulate(input logic se);
    int   n;
    logic frozen, last;
    @(posedge core_clk) want_mod <= 1'b1;
    wait_for(1, 1'b1, ENTRY_CYCLES, n);
    tick(1);
    chk(b_oe_n, ~se);
    chk(hold, 1'b1);
    frozen = dmo;
    last   = rdy;
    n      = 0;
    @(posedge core_clk) sense <= ~frozen;
    for (int i = 0; i < 48; i++) begin
      tick(1);
      n += (rdy !== last);
      chk(ant_b, se & ~rdy);
      last = rdy;
    end
    chk(dmo, frozen);
    chk_n(n, 8, 48);
    chk(rdy_oe_n, 1'b0);
    @(posedge core_clk) want_mod <= 1'b0;
    wait_for(2, 1'b0, RESUME_RF_CLOCKS * RFP + 40, n);
    chk_n(n, RESUME_RF_CLOCKS * RFP - 16, RESUME_RF_CLOCKS * RFP + 40);
    chk(a_oe_n, 1'b0);
    tick(8);
    chk(dmo, sense);
  endtask

  // Short: field off and ready low until a sleep cycle
  task automatic short_test();
    @(posedge core_clk) short_det <= 1'b1;
    tick(8);
    for (int i = 0; i < 32; i++) begin
      if (i == 8) begin
        @(posedge core_clk) short_det <= 1'b0;
      end
      tick(2);
      chk(a_oe_n, 1'b1);
      chk(rdy, 1'b0);
      chk(rdy_oe_n, 1'b0);
    end
  endtask

  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n    <= 1'b1;
    want_mod <= 1'b1;
    tick(16);
    chk(a_oe_n, 1'b1);
    @(posedge core_clk) want_mod <= 1'b0;
    for (int se = 0; se < 2; se++) begin
      wake(se[0]);
      demod_run();
      modulate(se[0]);
      $display("wiring %0d test done", se);
    end
    short_test();
    wake(1'b0);
    $display("short test done");
    results();
  end

  initial begin
    #2000000;
    error_cnt++;
    results();
  end
endmodule
